// >>> rtl/cmp_ctrl_pkg.sv
// Purpose: constants for the dual comparator and reference ladder control block
// Assumes: 16-bit register port, word index addressing
// Notes: offsets and layouts are local choices
package cmp_ctrl_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int NUM_CMP = 2;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFF_CMP_CTRL = 3'h0;
  localparam logic [2:0] OFF_REF_CTRL = 3'h1;
  localparam logic [2:0] OFF_STATUS = 3'h2;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h3;
  // ---------------------------------------------------------------
  // comparator control fields, comparator n at bit base + n; halt-in-idle is one shared bit
  // ---------------------------------------------------------------
  localparam int B_ON = 0;
  localparam int B_PIN = 2;
  localparam int B_INV = 4;
  localparam int B_NEG = 6;
  localparam int B_POS = 8;
  localparam int B_HALT = 15;
  // ---------------------------------------------------------------
  // reference control fields
  // ---------------------------------------------------------------
  localparam int B_TAP = 0;
  localparam int TAP_W = 4;
  localparam int B_SSEL = 4;
  localparam int B_RANGE = 5;
  localparam int B_ROE = 6;
  localparam int B_REN = 7;
  // ---------------------------------------------------------------
  // status fields: result levels and toggle flags
  // ---------------------------------------------------------------
  localparam int B_RES = 0;
  localparam int B_FLAG = 8;
  localparam logic [15:0] RST_ZERO = 16'h0000;
endpackage

// >>> rtl/cmp_channel.sv
// Purpose: one comparator channel: input sync, gating, inversion, toggle detect
// Assumes: raw comparison arrives asynchronously from the analog core
// Notes: a disabled or halted channel holds its result and raises no events
`timescale 1ns/1ps
module cmp_channel (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_raw,
  input wire logic i_run,
  input wire logic i_invert,
  output logic o_level,
  output logic o_toggle
);
  logic sync_a;
  logic sync_b;
  logic level;
  logic next_level;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= i_raw;
      sync_b <= sync_a;
    end
  end

  assign next_level = sync_b ^ i_invert; // RULE3

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      level <= 1'b0;
      o_toggle <= 1'b0;
    end else begin
      o_toggle <= 1'b0;
      if (i_run) begin // RULE1 RULE12
        level <= next_level;
        o_toggle <= (next_level != level); // RULE6
      end
    end
  end

  assign o_level = level; // RULE7
endmodule

// >>> rtl/dual_comparator_control.sv
// Purpose: control and status for two comparators and the reference ladder
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: analog parts sit outside; this block drives their selects
// Notes on behaviour
// RULE1: each comparator runs only while its own enable bit is set.
// RULE2: a set pin-drive bit drives the result onto the comparator pin, else the pin is released; the pin is driven only with the enable bit also set.
// RULE3: a set invert bit complements the reported and pin-driven result.
// RULE4: the inverting-input select, when clear, picks the negative input pin.
// RULE5: the noninverting-input select picks the reference when clear, the positive pin when set.
// RULE6: each comparator has a flag set by hardware whenever its result changes.
// RULE7: software reads each comparator's result level after inversion.
// RULE8: the ladder has an enable bit and a separate pin-drive bit for its output.
// RULE9: the supply select takes the analog supply pair when clear, the alternative when set.
// RULE10: a range bit selects between two ranges, one stepping by source over 32.
// RULE11: a 4-bit tap value selects the ladder output; zero in the 32-step range gives 0.25.
// RULE12: with halt-in-idle set, comparators and event detection stop while idle.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module dual_comparator_control (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_idle,
  input wire logic [1:0] i_cmp_raw,
  output logic [1:0] o_cmp_analog_on,
  output logic [1:0] o_cmp_pin_out,
  output logic [1:0] o_cmp_pin_oe,
  output logic [1:0] o_inverting_input_sel,
  output logic [1:0] o_noninverting_input_sel,
  output logic o_ref_ladder_on,
  output logic o_ref_pin_drive_on,
  output logic o_ref_supply_sel,
  output logic o_ref_range_sel,
  output logic [3:0] o_ref_tap_value,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  logic [1:0] cmp_on;
  logic [1:0] cmp_pin_drive_on;
  logic [1:0] cmp_invert_sel;
  logic [1:0] inverting_input_sel;
  logic [1:0] noninverting_input_sel;
  logic halt_in_idle;
  logic [15:0] reference_control_reg;
  logic [1:0] cmp_toggle_flag;
  logic [1:0] irq_mask;
  logic [1:0] cmp_result_status;
  logic [1:0] toggle;
  logic [1:0] run;
  logic idle_a;
  logic idle_b;
  logic wr_cmp;
  logic wr_ref;
  logic wr_stat;
  logic wr_mask;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  assign wr_cmp = i_wr && hit(i_addr, cmp_ctrl_pkg::OFF_CMP_CTRL);
  assign wr_ref = i_wr && hit(i_addr, cmp_ctrl_pkg::OFF_REF_CTRL);
  assign wr_stat = i_wr && hit(i_addr, cmp_ctrl_pkg::OFF_STATUS);
  assign wr_mask = i_wr && hit(i_addr, cmp_ctrl_pkg::OFF_IRQ_MASK);

  // idle comes from the power controller on its own timing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idle_a <= 1'b0;
      idle_b <= 1'b0;
    end else begin
      idle_a <= i_idle;
      idle_b <= idle_a;
    end
  end

  // ---------------------------------------------------------------
  // comparator control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmp_on <= 2'h0;
      cmp_pin_drive_on <= 2'h0;
      cmp_invert_sel <= 2'h0;
      inverting_input_sel <= 2'h0;
      noninverting_input_sel <= 2'h0;
      halt_in_idle <= 1'b0;
    end else if (wr_cmp) begin
      cmp_on <= i_wdata[cmp_ctrl_pkg::B_ON +: 2]; // RULE1
      cmp_pin_drive_on <= i_wdata[cmp_ctrl_pkg::B_PIN +: 2]; // RULE2
      cmp_invert_sel <= i_wdata[cmp_ctrl_pkg::B_INV +: 2]; // RULE3
      inverting_input_sel <= i_wdata[cmp_ctrl_pkg::B_NEG +: 2]; // RULE4
      noninverting_input_sel <= i_wdata[cmp_ctrl_pkg::B_POS +: 2]; // RULE5
      halt_in_idle <= i_wdata[cmp_ctrl_pkg::B_HALT]; // RULE12
    end
  end

  // ---------------------------------------------------------------
  // reference control register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      reference_control_reg <= cmp_ctrl_pkg::RST_ZERO;
    end else if (wr_ref) begin
      reference_control_reg <= {8'h00, i_wdata[7:0]}; // RULE8 RULE9 RULE10 RULE11
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < cmp_ctrl_pkg::NUM_CMP; g++) begin : g_ch
      assign run[g] = cmp_on[g] && !(halt_in_idle && idle_b); // RULE1 RULE12
      cmp_channel u_ch (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_raw(i_cmp_raw[g]),
        .i_run(run[g]),
        .i_invert(cmp_invert_sel[g]),
        .o_level(cmp_result_status[g]),
        .o_toggle(toggle[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // toggle flags and interrupt; a new event beats a clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cmp_toggle_flag <= 2'h0;
    end else begin
      cmp_toggle_flag <= (wr_stat ? cmp_toggle_flag & ~i_wdata[cmp_ctrl_pkg::B_FLAG +: 2]
                                  : cmp_toggle_flag) | toggle; // RULE6
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_mask <= 2'h0;
    end else if (wr_mask) begin
      irq_mask <= i_wdata[cmp_ctrl_pkg::B_FLAG +: 2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(cmp_toggle_flag & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= cmp_ctrl_pkg::RST_ZERO;
    end else if (i_rd) begin
      unique case (i_addr)
        cmp_ctrl_pkg::OFF_CMP_CTRL: o_rdata <= {halt_in_idle, 5'h00, noninverting_input_sel,
          inverting_input_sel, cmp_invert_sel, cmp_pin_drive_on, cmp_on};
        cmp_ctrl_pkg::OFF_REF_CTRL: o_rdata <= reference_control_reg;
        cmp_ctrl_pkg::OFF_STATUS: o_rdata <= {6'h00, cmp_toggle_flag,
          6'h00, cmp_result_status}; // RULE7
        cmp_ctrl_pkg::OFF_IRQ_MASK: o_rdata <= {6'h00, irq_mask, 8'h00};
        default: o_rdata <= cmp_ctrl_pkg::RST_ZERO;
      endcase
    end else begin
      o_rdata <= cmp_ctrl_pkg::RST_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // analog side controls, all registered
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cmp_analog_on <= 2'h0;
      o_cmp_pin_out <= 2'h0;
      o_cmp_pin_oe <= 2'h0;
      o_inverting_input_sel <= 2'h0;
      o_noninverting_input_sel <= 2'h0;
      o_ref_ladder_on <= 1'b0;
      o_ref_pin_drive_on <= 1'b0;
      o_ref_supply_sel <= 1'b0;
      o_ref_range_sel <= 1'b0;
      o_ref_tap_value <= 4'h0;
    end else begin
      o_cmp_analog_on <= run; // RULE1
      o_cmp_pin_out <= cmp_result_status; // RULE3
      o_cmp_pin_oe <= cmp_pin_drive_on & cmp_on; // RULE2
      o_inverting_input_sel <= inverting_input_sel; // RULE4
      o_noninverting_input_sel <= noninverting_input_sel; // RULE5
      o_ref_ladder_on <= reference_control_reg[cmp_ctrl_pkg::B_REN]; // RULE8
      o_ref_pin_drive_on <= reference_control_reg[cmp_ctrl_pkg::B_ROE]; // RULE8
      o_ref_supply_sel <= reference_control_reg[cmp_ctrl_pkg::B_SSEL]; // RULE9
      o_ref_range_sel <= reference_control_reg[cmp_ctrl_pkg::B_RANGE]; // RULE10
      o_ref_tap_value <= reference_control_reg[cmp_ctrl_pkg::B_TAP +: cmp_ctrl_pkg::TAP_W]; // RULE11
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_flag_on_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    toggle[0] |=> cmp_toggle_flag[0]) else $error("toggle flag 0 not set");
  a_halt_no_event: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
    (halt_in_idle && idle_b) |=> !toggle[0] && !toggle[1]) else $error("event while halted");
  a_off_no_event: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    !cmp_on[1] |=> !toggle[1]) else $error("event while disabled");
  a_pin_oe_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    ##1 o_cmp_pin_oe[0] == $past(cmp_pin_drive_on[0] & cmp_on[0]))
    else $error("pin enable wrong");
  a_pin_equals_result: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
    ##1 o_cmp_pin_out == $past(cmp_result_status)) else $error("pin differs from result");
  a_status_read: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    (i_rd && i_addr == cmp_ctrl_pkg::OFF_STATUS) |=> o_rdata[1:0] == $past(cmp_result_status))
    else $error("status read wrong");
  a_inv_sel_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    wr_cmp |=> ##1 o_inverting_input_sel == $past(i_wdata[7:6], 2)) else $error("neg sel");
  a_pos_sel_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    wr_cmp |=> ##1 o_noninverting_input_sel == $past(i_wdata[9:8], 2)) else $error("pos sel");
  a_ref_write_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    wr_ref |=> ##1 o_ref_ladder_on == $past(i_wdata[7], 2)) else $error("ladder enable");
  a_ref_tap_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE11
    wr_ref |=> ##1 o_ref_tap_value == $past(i_wdata[3:0], 2)) else $error("tap value");
  a_ref_supply_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    wr_ref |=> ##1 o_ref_supply_sel == $past(i_wdata[4], 2)) else $error("supply select");
  a_ref_range_out: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
    wr_ref |=> ##1 o_ref_range_sel == $past(i_wdata[5], 2)) else $error("range select");

  // ---------------------------------------------------------------
  // sequences for the paths that take more than one step
  // ---------------------------------------------------------------
  // a register write lands one edge after the strobe and reaches the
  // analog side on the next, so output checks start after this
  sequence s_cmp_landed;
    wr_cmp ##1 1'b1;
  endsequence

  sequence s_ref_landed;
    wr_ref ##1 1'b1;
  endsequence

  sequence s_flag1_set;
    ##1 cmp_toggle_flag[1];
  endsequence

  // the interrupt lags the flags by one edge so that it comes from a flop
  sequence s_irq_raised;
    ##1 o_irq;
  endsequence

  // ---------------------------------------------------------------
  // checks on events, interrupt and read slot
  // ---------------------------------------------------------------
  a_flag1_on_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    toggle[1] |-> s_flag1_set)
    else $error("toggle flag 1 not set");
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (cmp_toggle_flag[0] && !(wr_stat && i_wdata[cmp_ctrl_pkg::B_FLAG]))
      |=> cmp_toggle_flag[0])
    else $error("toggle flag 0 lost");
  a_flag_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (wr_stat && i_wdata[cmp_ctrl_pkg::B_FLAG + 1] && !toggle[1]) |=> !cmp_toggle_flag[1])
    else $error("toggle flag 1 not cleared");
  a_toggle_on_change: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    toggle[0] == (cmp_result_status[0] != $past(cmp_result_status[0])))
    else $error("event and level change disagree");
  a_halt_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
    (halt_in_idle && idle_b) |=> $stable(cmp_result_status))
    else $error("level moved while halted");
  a_off_freeze: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    !run[0] |=> $stable(cmp_result_status[0]))
    else $error("level moved while stopped");
  a_run_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    ##1 o_cmp_analog_on == $past(run))
    else $error("analog enable wrong");
  a_pin_oe_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    !cmp_on[1] |=> !o_cmp_pin_oe[1])
    else $error("pin driven while disabled");
  a_pin_oe_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    s_cmp_landed |=> o_cmp_pin_oe == $past(i_wdata[cmp_ctrl_pkg::B_PIN +: 2]
      & i_wdata[cmp_ctrl_pkg::B_ON +: 2], 2))
    else $error("pin enable after write wrong");
  a_ref_pin_write: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    s_ref_landed |=> o_ref_pin_drive_on == $past(i_wdata[cmp_ctrl_pkg::B_ROE], 2))
    else $error("reference pin drive wrong");

  a_irq_on_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    (|(cmp_toggle_flag & irq_mask)) |-> s_irq_raised)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
    !(|(cmp_toggle_flag & irq_mask)) |=> !o_irq)
    else $error("interrupt without a flag");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    !i_rd |=> o_rdata == cmp_ctrl_pkg::RST_ZERO)
    else $error("read data outside the read slot");
endmodule

// >>> tb/testbench.sv
// Purpose: self-checking bench for the dual comparator control block
// Assumes: register map and latencies as handed over; raw inputs driven directly
// Notes: fixed waits cover the sync and register lag with margin
`timescale 1ns/1ps
module testbench;
  logic i_clk, i_rst_n, i_wr, i_rd, i_idle, o_ref_ladder_on, o_ref_pin_drive_on;
  logic o_ref_supply_sel, o_ref_range_sel, o_irq;
  logic [2:0] i_addr;
  logic [15:0] i_wdata, o_rdata, rd;
  logic [1:0] i_cmp_raw, o_cmp_analog_on, o_cmp_pin_out, o_cmp_pin_oe;
  logic [1:0] o_inverting_input_sel, o_noninverting_input_sel;
  logic [3:0] o_ref_tap_value;
  int fail_count = 0;
  int checked = 0;

  dual_comparator_control u_dual_comparator_control (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_idle(i_idle), .i_cmp_raw(i_cmp_raw), .o_cmp_analog_on(o_cmp_analog_on),
    .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_pin_oe(o_cmp_pin_oe),
    .o_inverting_input_sel(o_inverting_input_sel),
    .o_noninverting_input_sel(o_noninverting_input_sel), .o_ref_ladder_on(o_ref_ladder_on),
    .o_ref_pin_drive_on(o_ref_pin_drive_on), .o_ref_supply_sel(o_ref_supply_sel),
    .o_ref_range_sel(o_ref_range_sel), .o_ref_tap_value(o_ref_tap_value), .o_irq(o_irq));

  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rdr(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_map;
    for (int a = 0; a < 8; a++) begin
      rdr(a[2:0], rd);
      chk(rd, 16'h0000);
    end
    wr(3'h5, 16'hffff);
    rdr(3'h5, rd);
    chk(rd, 16'h0000);
    chk({14'h0, o_cmp_analog_on}, 16'h0000);
  endtask

  task automatic t_config;
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h0217);
    cyc(8);
    chk({14'h0, o_cmp_analog_on}, 16'h0003);
    chk({14'h0, o_cmp_pin_oe}, 16'h0001);
    chk({14'h0, o_cmp_pin_out}, 16'h0001);
    chk({14'h0, o_inverting_input_sel}, 16'h0000);
    chk({14'h0, o_noninverting_input_sel}, 16'h0002);
    rdr(cmp_ctrl_pkg::OFF_CMP_CTRL, rd);
    chk(rd, 16'h0217);
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h03cc);
    cyc(8);
    chk({14'h0, o_cmp_pin_oe}, 16'h0000);
    chk({14'h0, o_inverting_input_sel}, 16'h0003);
    chk({14'h0, o_noninverting_input_sel}, 16'h0003);
    chk({14'h0, o_cmp_analog_on}, 16'h0000);
  endtask

  task automatic t_toggle;
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h000f);
    // let the enable's own event land first: a set in the clear cycle wins
    cyc(4);
    wr(cmp_ctrl_pkg::OFF_STATUS, 16'h0300);
    wr(cmp_ctrl_pkg::OFF_IRQ_MASK, 16'h0300);
    cyc(8);
    chk({15'h0, o_irq}, 16'h0000);
    @(posedge i_clk) i_cmp_raw <= 2'b01;
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0101);
    chk({15'h0, o_irq}, 16'h0001);
    chk({14'h0, o_cmp_pin_out}, 16'h0001);
    wr(cmp_ctrl_pkg::OFF_IRQ_MASK, 16'h0000);
    cyc(3);
    chk({15'h0, o_irq}, 16'h0000);
    wr(cmp_ctrl_pkg::OFF_STATUS, 16'h0100);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0001);
    // inverting comparator 1 alone must flip its level and raise its own flag
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h002f);
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0203);
    // a disabled comparator freezes its level and raises nothing
    wr(cmp_ctrl_pkg::OFF_STATUS, 16'h0300);
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h002e);
    @(posedge i_clk) i_cmp_raw <= 2'b00;
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0003);
  endtask

  task automatic t_idle;
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h8003);
    cyc(4);
    wr(cmp_ctrl_pkg::OFF_STATUS, 16'h0300);
    @(posedge i_clk) i_idle <= 1'b1;
    cyc(8);
    chk({14'h0, o_cmp_analog_on}, 16'h0000);
    @(posedge i_clk) i_cmp_raw <= 2'b11;
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd[9:8], 16'h0000);
    @(posedge i_clk) i_idle <= 1'b0;
    cyc(8);
    chk({14'h0, o_cmp_analog_on}, 16'h0003);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0303);
    // with halt-in-idle clear the comparators keep running through idle
    wr(cmp_ctrl_pkg::OFF_CMP_CTRL, 16'h0003);
    @(posedge i_clk) i_idle <= 1'b1;
    cyc(8);
    chk({14'h0, o_cmp_analog_on}, 16'h0003);
    wr(cmp_ctrl_pkg::OFF_STATUS, 16'h0300);
    @(posedge i_clk) i_cmp_raw <= 2'b00;
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_STATUS, rd);
    chk(rd, 16'h0300);
    @(posedge i_clk) i_idle <= 1'b0;
  endtask

  task automatic t_ref;
    wr(cmp_ctrl_pkg::OFF_REF_CTRL, 16'hffff);
    cyc(8);
    rdr(cmp_ctrl_pkg::OFF_REF_CTRL, rd);
    chk(rd, 16'h00ff);
    chk({o_ref_ladder_on, o_ref_pin_drive_on}, 16'h0003);
    chk({15'h0, o_ref_supply_sel}, 16'h0001);
    chk({15'h0, o_ref_range_sel}, 16'h0001);
    chk({12'h0, o_ref_tap_value}, 16'h000f);
    wr(cmp_ctrl_pkg::OFF_REF_CTRL, 16'h0080);
    cyc(8);
    chk({o_ref_ladder_on, o_ref_pin_drive_on}, 16'h0002);
    chk({o_ref_supply_sel, o_ref_range_sel}, 16'h0000);
    chk({12'h0, o_ref_tap_value}, 16'h0000);
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, reset and main sequence
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 16'h0000;
    i_idle = 1'b0;
    i_cmp_raw = 2'b00;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset_map();
    t_config();
    t_toggle();
    t_idle();
    t_ref();
    wrap_up();
  end
endmodule
